// file: logic/qss_sequencer.sv
`timescale 1ns/1ps
`include "qss_cfg.svh"
module qss_sequencer #(
  parameter int NUM = `QSS_NUM_SUPPLIES
) (
  input  wire logic           clock,
  input  wire logic           reset,
  input  wire logic [NUM-1:0] supply_good_sense,
  input  wire logic           on_command,
  input  wire logic           inter_supply_delay_timer_expired,
  input  wire logic           inter_supply_delay_timer_open,
  input  wire logic           power_good_timeout_expired,
  input  wire logic           power_good_timeout_grounded,
  input  wire logic           hysteresis_chain_config,
  input  wire logic           fault_line_in,
  output logic      [NUM-1:0] supply_enable,
  output logic                inter_supply_delay_timer_run,
  output logic                power_good_timeout_run,
  output logic                done_out,
  output logic                done_oe,
  output logic                fault_out,
  output logic                fault_oe,
  output logic                fault_internal,
  output logic                chain_not_first
);
  import qss_pkg::*;

  localparam int IW = NUM + 6;
  typedef struct packed {
    qss_state_t       st;
    qss_fault_t       flt;
    logic [1:0]       idx;
    logic [NUM-1:0]   en;
    logic             tmr_run;
    logic             pgt_run;
    logic             done_low;
    logic             fault_low;
    logic             flt_int;
    logic             chain_nf;
    logic             strap_taken;
    logic [1:0]       rel_wait;
  } qss_state_s_t;

  qss_state_s_t s_q;
  qss_state_s_t s_d;
  logic [IW-1:0] raw_in;
  logic [IW-1:0] sync_in;
  logic [NUM-1:0] good;
  logic on_s;
  logic tmr_exp;
  logic tmr_open;
  logic pgt_exp;
  logic pgt_gnd;
  logic fault_ext;
  logic good_cur;
  logic off_cur;
  logic delay_done;
  logic seq_err;
  logic int_fault;
  logic [NUM-1:0] should_on;

  // ---------------------------------------------
  // input synchronisation
  // ---------------------------------------------
  assign raw_in = {supply_good_sense, on_command, inter_supply_delay_timer_expired,
                   inter_supply_delay_timer_open, power_good_timeout_expired,
                   power_good_timeout_grounded, ~fault_line_in};
  qss_sync #(
    .WIDTH (IW)
  ) qss_sync_i (
    .clock (clock),
    .reset (reset),
    .din   (raw_in),
    .dout  (sync_in)
  );

  // ---------------------------------------------
  // decoded conditions
  // ---------------------------------------------
  assign good      = sync_in[IW-1:6];
  assign on_s      = sync_in[5];
  assign tmr_exp   = sync_in[4];
  assign tmr_open  = sync_in[3];
  assign pgt_exp   = sync_in[2];
  assign pgt_gnd   = sync_in[1];
  // own pull-down and its synchroniser echo are masked so only others count
  assign fault_ext = sync_in[0] && !s_q.fault_low && (s_q.rel_wait == 2'h0);
  assign good_cur  = good[s_q.idx];
  assign off_cur   = !good[s_q.idx];
  assign delay_done = tmr_exp || tmr_open;

  // enabled supplies must stay good; sequence error otherwise
  generate
    for (genvar g = 0; g < NUM; g++) begin : g_chk
      always_comb begin
        should_on[g] = 1'b0;
        if (s_q.st == QSS_DONE) begin
          should_on[g] = 1'b1;
        end else if (s_q.st == QSS_ON_WAIT || s_q.st == QSS_ON_DELAY) begin
          should_on[g] = (g < int'(s_q.idx));
        end else if (s_q.st == QSS_OFF_WAIT || s_q.st == QSS_OFF_DLY) begin
          should_on[g] = (g < int'(s_q.idx));
        end
      end
    end
  endgenerate

  always_comb begin
    seq_err = |(should_on & ~good);
    int_fault = seq_err;
    unique case (s_q.st)
      QSS_ON_DELAY, QSS_ON_WAIT: begin
        if (!on_s) int_fault = 1'b1;
        if (s_q.st == QSS_ON_WAIT && pgt_exp && !pgt_gnd && !good_cur) begin
          int_fault = 1'b1;
        end
      end
      QSS_OFF_WAIT, QSS_OFF_DLY: begin
        if (on_s) int_fault = 1'b1;
      end
      default: ;
    endcase
  end

  // ---------------------------------------------
  // sequencing state machine
  // ---------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tmr_run = 1'b0;
    s_d.pgt_run = 1'b0;
    if (!s_q.strap_taken) begin
      s_d.chain_nf    = hysteresis_chain_config;
      s_d.strap_taken = 1'b1;
    end
    if (s_q.st != QSS_FAULT && (int_fault || fault_ext)) begin
      s_d.st        = QSS_FAULT;
      s_d.en        = '0;
      s_d.fault_low = 1'b1;
      s_d.flt       = int_fault ? QSS_FLT_INT : QSS_FLT_EXT;
      s_d.flt_int   = int_fault;
      s_d.done_low  = 1'b0;
      s_d.rel_wait  = 2'h0;
    end else begin
      unique case (s_q.st)
        QSS_IDLE: begin
          if (on_s) begin
            s_d.st  = QSS_ON_DELAY;
            s_d.idx = 2'h0;
          end
        end
        QSS_ON_DELAY: begin
          s_d.tmr_run = !delay_done;
          if (delay_done && !s_q.tmr_run) begin
            s_d.tmr_run = 1'b1;
          end else if (delay_done) begin
            s_d.en[s_q.idx] = 1'b1;
            s_d.st = QSS_ON_WAIT;
          end
        end
        QSS_ON_WAIT: begin
          s_d.pgt_run = !pgt_gnd && !good_cur;
          if (good_cur) begin
            s_d.pgt_run = 1'b0;
            if (s_q.idx == 2'(NUM - 1)) begin
              s_d.st       = QSS_DONE;
              s_d.done_low = 1'b1;
            end else begin
              s_d.idx = s_q.idx + 2'h1;
              s_d.st  = QSS_ON_DELAY;
            end
          end
        end
        QSS_DONE: begin
          if (!on_s) begin
            s_d.st  = QSS_OFF_WAIT;
            s_d.idx = 2'(NUM - 1);
            s_d.en[NUM-1] = 1'b0;
          end
        end
        QSS_OFF_WAIT: begin
          if (off_cur) begin
            if (s_q.idx == 2'h0) begin
              s_d.st       = QSS_IDLE;
              s_d.done_low = 1'b0;
            end else begin
              s_d.st = QSS_OFF_DLY;
            end
          end
        end
        QSS_OFF_DLY: begin
          s_d.tmr_run = !delay_done;
          if (delay_done && !s_q.tmr_run) begin
            s_d.tmr_run = 1'b1;
          end else if (delay_done) begin
            s_d.idx = s_q.idx - 2'h1;
            s_d.en[s_q.idx - 2'h1] = 1'b0;
            s_d.st = QSS_OFF_WAIT;
          end
        end
        QSS_FAULT: begin
          s_d.en = '0;
          if (s_q.rel_wait != 2'h0) begin
            s_d.rel_wait = s_q.rel_wait - 2'h1;
          end
          if ((|good) || on_s) begin
            s_d.fault_low = 1'b1;
            s_d.rel_wait  = 2'h0;
          end else if (s_q.fault_low) begin
            // let go first, then judge the line once the echo has passed
            s_d.fault_low = 1'b0;
            s_d.rel_wait  = `QSS_RELEASE_WAIT;
          end else if (s_q.rel_wait == 2'h0 && (s_q.flt_int || !fault_ext)) begin
            s_d.st      = QSS_IDLE;
            s_d.flt     = QSS_FLT_NONE;
            s_d.flt_int = 1'b0;
          end
        end
        default: begin
          s_d.st = QSS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q.st          <= QSS_IDLE;
      s_q.flt         <= QSS_FLT_NONE;
      s_q.idx         <= 2'h0;
      s_q.en          <= `QSS_ENABLE_RESET;
      s_q.tmr_run     <= 1'b0;
      s_q.pgt_run     <= 1'b0;
      s_q.done_low    <= 1'b0;
      s_q.fault_low   <= 1'b0;
      s_q.flt_int     <= 1'b0;
      s_q.chain_nf    <= `QSS_CHAIN_FIRST;
      s_q.strap_taken <= 1'b0;
      s_q.rel_wait    <= 2'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign supply_enable                = s_q.en;
  assign inter_supply_delay_timer_run = s_q.tmr_run;
  assign power_good_timeout_run       = s_q.pgt_run;
  assign done_out                     = 1'b0;
  assign done_oe                      = !s_q.done_low;
  assign fault_out                    = 1'b0;
  assign fault_oe                     = !s_q.fault_low;
  assign fault_internal               = s_q.flt_int;
  assign chain_not_first              = s_q.chain_nf;
endmodule // qss_sequencer

// file: shared/qss_cfg.svh
// How it works
// - power on: after a supply is good, wait delay timer before next enable.
// - power off: after a supply is off, wait delay timer before next disable.
// - open delay timer node means the minimum delay, no programmed wait.
// - power-good timeout starts each time an enable rises in power on.
// - power-good timeout clears when the enabled supply reports good, restarts at the next enable.
// - power-good timeout is watched only during power on.
// - power-good timeout supervision off when its input is grounded.
// - a supply counts on or off when its sense crosses the common threshold.
// - detect sequence, command, timeout and external faults.
// - any fault drops all four enables at once.
// - a fault from own supplies pulls the shared fault line low at once.
// - fault holds until all sense inputs and on command are low.
// - external fault also waits for the fault line to be released by others.
// - chain position read from the hysteresis config strap.
// - chain handshake on done to on node by levels only.
// - on command high starts power on, beginning with the delay timer.
// - on command low after done starts power off, fourth supply first.
// - done pulls low when the last supply is on, releases after power off.
// - power-good timeout expiry before supply good raises a fault.
`ifndef QSS_CFG_SVH
`define QSS_CFG_SVH
`define QSS_NUM_SUPPLIES 4
`define QSS_SYNC_STAGES  2
`define QSS_ENABLE_RESET 4'h0
`define QSS_CHAIN_FIRST  1'b0
`define QSS_RELEASE_WAIT 2'h2
`endif

// file: shared/qss_pkg.sv
package qss_pkg;
  typedef enum logic [2:0] {
    QSS_IDLE     = 3'b000,
    QSS_ON_DELAY = 3'b001,
    QSS_ON_WAIT  = 3'b011,
    QSS_DONE     = 3'b010,
    QSS_OFF_WAIT = 3'b110,
    QSS_OFF_DLY  = 3'b111,
    QSS_FAULT    = 3'b101
  } qss_state_t;
  typedef enum logic [1:0] {
    QSS_FLT_NONE = 2'h0,
    QSS_FLT_INT  = 2'h1,
    QSS_FLT_EXT  = 2'h2
  } qss_fault_t;
endpackage

// file: logic/qss_sync.sv
`timescale 1ns/1ps
`include "qss_cfg.svh"
module qss_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } qss_sync_st_t;
  qss_sync_st_t s_q;
  qss_sync_st_t s_d;
  // ---------------------------------------------
  // two flop synchroniser
  // ---------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.stab = s_q.meta;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign dout = s_q.stab;
endmodule // qss_sync

// file: verif/qss_sequencer_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module qss_sequencer_checker #(
  parameter int NUM = 4
) (
  input wire logic           clock,
  input wire logic           reset,
  input wire logic [NUM-1:0] supply_good_sense,
  input wire logic           on_command,
  input wire logic           power_good_timeout_grounded,
  input wire logic [NUM-1:0] supply_enable,
  input wire logic           inter_supply_delay_timer_run,
  input wire logic           power_good_timeout_run,
  input wire logic           done_oe,
  input wire logic           fault_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence up_s;
    $countones(supply_enable) > $countones($past(supply_enable));
  endsequence
  sequence held_s;
    (on_command || (|supply_good_sense))[*4];
  endsequence
  fault_drop_a: assert property ($fell(fault_oe) |-> supply_enable == '0)
    else $error("enables still high at fault");
  enable_order_a: assert property (((supply_enable + 1) & supply_enable) == 0)
    else $error("enables out of order");
  on_delay_a: assert property (up_s |-> $past(inter_supply_delay_timer_run) ||
    $past(inter_supply_delay_timer_run, 2)) else $error("enable without delay");
  off_delay_a: assert property (fault_oe && $countones($past(supply_enable)) < NUM &&
    $countones(supply_enable) < $countones($past(supply_enable)) |->
    $past(inter_supply_delay_timer_run) || $past(inter_supply_delay_timer_run, 2))
    else $error("disable without delay");
  pgt_start_a: assert property (up_s ##0 !power_good_timeout_grounded |->
    ##[0:2] power_good_timeout_run) else $error("timeout not started");
  pgt_ground_a: assert property (power_good_timeout_grounded[*4] |->
    !power_good_timeout_run) else $error("timeout runs while grounded");
  pgt_stop_a: assert property (((supply_good_sense == supply_enable) &&
    (supply_enable != '0))[*4] |-> !power_good_timeout_run)
    else $error("timeout still running with supply good");
  pgt_on_only_a: assert property (!done_oe |-> !power_good_timeout_run)
    else $error("timeout runs after power on");
  done_set_a: assert property ($fell(done_oe) |-> &supply_enable)
    else $error("done before last supply");
  done_clear_a: assert property ($rose(done_oe) |-> supply_enable == '0)
    else $error("done released with supply on");
  fault_hold_a: assert property (held_s ##0 !fault_oe |=> !fault_oe)
    else $error("fault cleared with inputs high");
endmodule // qss_sequencer_checker

bind qss_sequencer qss_sequencer_checker #(.NUM(NUM)) qss_sequencer_checker_i (
  .clock(clock), .reset(reset), .supply_good_sense(supply_good_sense),
  .on_command(on_command), .power_good_timeout_grounded(power_good_timeout_grounded),
  .supply_enable(supply_enable), .inter_supply_delay_timer_run(inter_supply_delay_timer_run),
  .power_good_timeout_run(power_good_timeout_run), .done_oe(done_oe), .fault_oe(fault_oe));

// file: verif/qss_supply_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// supplies and timer capacitors
// ----------------------------------------
module qss_supply_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [3:0] supply_enable,
  input  wire logic       tmr_run,
  input  wire logic       pgt_run,
  input  wire logic [3:0] stall,
  input  wire logic [3:0] lat,
  output logic      [3:0] supply_good_sense,
  output logic            tmr_expired,
  output logic            pgt_expired
);
  logic [3:0] scnt;
  logic [3:0] tcnt;
  logic [5:0] pcnt;
  always @(posedge clock) begin
    if (reset) begin
      scnt <= 4'h0;
      tcnt <= 4'h0;
      pcnt <= 6'h0;
      supply_good_sense <= 4'h0;
    end else begin
      tcnt <= tmr_run ? tcnt + 4'h1 : 4'h0;
      pcnt <= pgt_run ? pcnt + 6'h1 : 6'h0;
      scnt <= ((supply_enable & ~stall) != supply_good_sense) ? scnt + 4'h1 : 4'h0;
      if (scnt == lat) supply_good_sense <= supply_enable & ~stall;
    end
  end
  assign tmr_expired = tcnt >= lat;
  assign pgt_expired = pcnt >= 6'h1e;
endmodule // qss_supply_model

// file: verif/qss_sequencer_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module qss_sequencer_tb;
  import qss_pkg::*;
  logic       clock = 0, reset = 1, on_command = 0, tmr_open = 0, pgt_gnd = 0, chain = 0;
  logic       ext_n = 1, tmr_exp, pgt_exp, tmr_run, pgt_run, done_oe, fault_oe, fault_int;
  logic       not_first, done_val, fault_val;
  logic [3:0] stall = 0, lat = 1, sense, en;
  logic [5:0] q[$], last;
  int         n_fail = 0, n_compared = 0;
  wire        fault_line = ext_n & fault_oe;
  initial forever #50 clock = ~clock;
  qss_sequencer qss_sequencer_i (.clock(clock), .reset(reset), .supply_good_sense(sense),
    .on_command(on_command), .inter_supply_delay_timer_expired(tmr_exp),
    .inter_supply_delay_timer_open(tmr_open), .power_good_timeout_expired(pgt_exp),
    .power_good_timeout_grounded(pgt_gnd), .hysteresis_chain_config(chain),
    .fault_line_in(fault_line), .supply_enable(en), .inter_supply_delay_timer_run(tmr_run),
    .power_good_timeout_run(pgt_run), .done_out(done_val), .done_oe(done_oe),
    .fault_out(fault_val),
    .fault_oe(fault_oe), .fault_internal(fault_int), .chain_not_first(not_first));
  qss_supply_model qss_supply_model_i (.clock(clock), .reset(reset), .supply_enable(en),
    .tmr_run(tmr_run), .pgt_run(pgt_run), .stall(stall), .lat(lat),
    .supply_good_sense(sense), .tmr_expired(tmr_exp), .pgt_expired(pgt_exp));
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drain;
    for (int i = 0; i < 600 && q.size() > 0; i++) @(posedge clock);
    check(7'(q.size()), 7'h0);
    repeat (4) @(posedge clock);
  endtask
  task automatic power_on;
    on_command <= 1;
    for (int k = 1; k < 5; k++) q.push_back({4'((1 << k) - 1), 2'b11});
    q.push_back(6'h3d);
    drain;
  endtask
  task automatic power_off;
    on_command <= 0;
    for (int k = 3; k >= 0; k--) q.push_back({4'((1 << k) - 1), 2'b01});
    q.push_back(6'h03);
    drain;
  endtask
  task automatic results;
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    if (reset) last <= 6'h03;
    else if ({en, done_oe, fault_oe} !== last) begin
      last <= {en, done_oe, fault_oe};
      check({1'b0, en, done_oe, fault_oe}, q.size() ? {1'b0, q.pop_front()} : 7'h7f);
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(32'h7990));
    @(posedge clock);
    chain <= 1'($urandom);
    repeat (15) @(posedge clock);
    reset <= 0;
    lat <= 4'(1 + $urandom % 4);
    repeat (3) @(posedge clock);
    check({6'h0, not_first}, {6'h0, chain});
    check({2'h0, done_val, fault_val, tmr_run, pgt_run, fault_int}, 7'h0);
    for (int m = 0; m < 2; m++) begin
      tmr_open <= 1'(m);
      pgt_gnd <= 1'(m);
      power_on();
      power_off();
    end
    tmr_open <= 0;
    pgt_gnd <= 0;
    stall <= 4'h4;
    on_command <= 1;
    q = '{6'h07, 6'h0f, 6'h1f, 6'h02};
    drain;
    check({6'h0, fault_int}, 7'h1);
    on_command <= 0;
    stall <= 0;
    q.push_back(6'h03);
    drain;
    pgt_gnd <= 1;
    stall <= 4'h2;
    on_command <= 1;
    q = '{6'h07, 6'h0f};
    drain;
    on_command <= 0;
    q = '{6'h02, 6'h03};
    drain;
    stall <= 0;
    pgt_gnd <= 0;
    power_on();
    ext_n <= 0;
    q.push_back(6'h02);
    drain;
    check({6'h0, fault_int}, 7'h0);
    on_command <= 0;
    q.push_back(6'h03);
    drain;
    repeat (30) @(posedge clock);
    ext_n <= 1;
    repeat (4) @(posedge clock);
    power_on();
    power_off();
    results();
  end
endmodule // qss_sequencer_tb
